// [design/pmc_pkg.sv]
// Constants and types shared by the power mode control block
package pmc_pkg;
  // Register map, byte address is four times the index
  localparam logic [7:0]  PMC_CTRL_INDEX   = 8'h11;
  localparam logic [7:0]  PMC_STAT_INDEX   = 8'h1F;
  localparam logic [7:0]  PMC_CTRL_ADDR    = {PMC_CTRL_INDEX[5:0], 2'b00};
  localparam logic [7:0]  PMC_STAT_ADDR    = {PMC_STAT_INDEX[5:0], 2'b00};
  // Control field positions
  localparam int          PMC_CLK_DIS_BIT  = 15;
  localparam int          PMC_PS_EN_BIT    = 14;
  localparam int          PMC_PS_SEL_LO    = 12;
  localparam int          PMC_SCR_BYP_BIT  = 11;
  localparam int          PMC_DEPTH_LO     = 8;
  // Writable bits 15:11 and 9:8; 10 and 7:0 read zero
  localparam logic [15:0] PMC_CTRL_WR_MASK = 16'hFB00;
  localparam logic [15:0] PMC_CTRL_RST     = 16'h0100;
  // Status field positions
  localparam int          PMC_ST_STATE_LO  = 0;
  localparam int          PMC_ST_CLKOFF    = 2;
  localparam int          PMC_ST_WOKEN     = 3;
  localparam int          PMC_ST_LEVEL_LO  = 4;
  localparam int          PMC_ST_OVF       = 8;
  // Bus responses
  localparam logic [1:0]  PMC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  PMC_RESP_DECERR  = 2'h3;
  // Loopback elastic buffer
  localparam int          PMC_FIFO_SLOTS   = 8;
  localparam logic [3:0]  PMC_DEPTH_NIB0   = 4'h4;
  localparam logic [3:0]  PMC_DEPTH_NIB1   = 4'h5;
  localparam logic [3:0]  PMC_DEPTH_NIB2   = 4'h6;
  localparam logic [3:0]  PMC_DEPTH_NIB3   = 4'h8;
  // Wake pulse period in active sleep
  localparam longint unsigned PMC_CLK_HZ       = 64'd40_000_000;
  localparam longint unsigned PMC_NLP_PERIOD_MS = 64'd1400;
  localparam longint unsigned PMC_NLP_CYC_L    =
    PMC_NLP_PERIOD_MS * PMC_CLK_HZ / 64'd1000;
  localparam int unsigned PMC_NLP_CYC = int'(PMC_NLP_CYC_L);
  localparam int          PMC_NLP_W        = 26;

  typedef enum logic [1:0] {
    PMC_SEL_NORMAL  = 2'b00,
    PMC_SEL_PDOWN   = 2'b01,
    PMC_SEL_ASLEEP  = 2'b10,
    PMC_SEL_PSLEEP  = 2'b11
  } pmc_sel_t;

  // Gray along run, power-down, active sleep, passive sleep
  typedef enum logic [1:0] {
    PMC_ST_RUN    = 2'b00,
    PMC_ST_PDOWN  = 2'b01,
    PMC_ST_ASLEEP = 2'b11,
    PMC_ST_PSLEEP = 2'b10
  } pmc_state_t;
endpackage : pmc_pkg

// [design/pmc_elastic_fifo.sv]
// Far-end loopback elastic nibble buffer
`timescale 1ns/1ps
module pmc_elastic_fifo
  import pmc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] depth_sel_i,
  input  wire logic       enable_i,
  input  wire logic       wr_valid_i,
  input  wire logic [3:0] wr_nibble_i,
  output logic            rd_valid_o,
  output logic      [3:0] rd_nibble_o,
  output logic      [3:0] level_o,
  output logic            overflow_o
);
  typedef struct packed {
    logic [PMC_FIFO_SLOTS-1:0][3:0] mem;
    logic [2:0]                     wptr;
    logic [2:0]                     rptr;
    logic [3:0]                     level;
    logic                           drain;
    logic                           rvalid;
    logic [3:0]                     rnib;
    logic                           ovf;
  } pmc_fifo_t;

  pmc_fifo_t r;
  pmc_fifo_t n;
  logic [3:0] target;
  logic       push;
  logic       pop;

  always_comb begin
    n = r;
    case (depth_sel_i)
      2'b00:   target = PMC_DEPTH_NIB0;
      2'b01:   target = PMC_DEPTH_NIB1;
      2'b10:   target = PMC_DEPTH_NIB2;
      default: target = PMC_DEPTH_NIB3;
    endcase
    // Hold back output until the chosen depth has built up
    pop  = r.drain && (r.level != 4'h0);
    push = enable_i && wr_valid_i && (r.level != 4'h8 || pop);
    n.ovf    = enable_i && wr_valid_i && !push;
    n.rvalid = pop;
    if (pop) begin
      n.rnib = r.mem[r.rptr];
      n.rptr = r.rptr + 3'h1;
    end
    if (push) begin
      n.mem[r.wptr] = wr_nibble_i;
      n.wptr        = r.wptr + 3'h1;
    end
    n.level = r.level + {3'h0, push} - {3'h0, pop};
    if (!enable_i) begin
      n.drain = 1'b0;
      n.level = 4'h0;
      n.rptr  = 3'h0;
      n.wptr  = 3'h0;
    end else if (!r.drain && r.level >= target) begin
      n.drain = 1'b1;
    end else if (r.drain && n.level == 4'h0) begin
      n.drain = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_valid_o  = r.rvalid;
  assign rd_nibble_o = r.rnib;
  assign level_o     = r.level;
  assign overflow_o  = r.ovf;
endmodule : pmc_elastic_fifo

// [design/pmc_power_ctrl.sv]
// Power mode control register with AXI4-Lite slave and loopback path
// Summary of operation
// - Control bit 15 set shuts down the internal clock circuits.
// - That shutdown only takes effect in the IEEE power-down state.
// - Bit 14 permits entry into the selected power save mode.
// - Bits 13:12 pick normal, power-down, active or passive sleep.
// - Active sleep sends a wake pulse every 1.4 s, wakes on energy.
// - Passive sleep sends no pulse and wakes on detected energy.
// - Bit 11 routes data around the 100 Mb/s scrambler.
// - Bits 10 and 7:0 ignore writes and read as zero.
// - Bits 9:8 size the loopback buffer to 4, 5, 6 or 8 nibbles.
// - Far-end loopback nibbles pass through that elastic buffer.
// - After reset depth reads 01 and the other fields read zero.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned NLP_PERIOD_CYC = PMC_NLP_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        energy_detect_i,
  input  wire logic        loopback_en_i,
  input  wire logic        rx_valid_i,
  input  wire logic [3:0]  rx_nibble_i,
  output logic             tx_valid_o,
  output logic [3:0]       tx_nibble_o,
  output logic             clocks_off_o,
  output logic             power_down_o,
  output logic             active_sleep_o,
  output logic             passive_sleep_o,
  output logic             nlp_pulse_o,
  output logic             scrambler_bypass_o
);
  localparam logic [PMC_NLP_W-1:0] NLP_RELOAD =
    PMC_NLP_W'(NLP_PERIOD_CYC - 1);

  typedef struct packed {
    logic                 awready;
    logic                 aw_got;
    logic [7:0]           awaddr;
    logic                 wready;
    logic                 w_got;
    logic [15:0]          wdata;
    logic                 wlane1;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [15:0]          rdata;
    logic [1:0]           rresp;
    logic [15:0]          ctrl;
    pmc_state_t           st;
    logic                 woken;
    logic                 ed_s1;
    logic                 ed_s2;
    logic [PMC_NLP_W-1:0] nlp_cnt;
    logic                 nlp;
    logic                 ovf;
    logic                 clk_off;
    logic                 pdown;
    logic                 asleep;
    logic                 psleep;
    logic                 scr_byp;
  } pmc_regs_t;

  pmc_regs_t r;
  pmc_regs_t n;

  logic       aw_hs;
  logic       w_hs;
  logic       have_aw;
  logic       have_w;
  logic       commit;
  logic       ctrl_wr;
  logic [7:0] waddr;
  logic [15:0] wval;
  logic       stat_rd;
  pmc_sel_t   sel;
  logic       fifo_ovf;
  logic [3:0] fifo_level;

  pmc_elastic_fifo u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .depth_sel_i (r.ctrl[PMC_DEPTH_LO+1:PMC_DEPTH_LO]),
    .enable_i    (loopback_en_i),
    .wr_valid_i  (rx_valid_i),
    .wr_nibble_i (rx_nibble_i),
    .rd_valid_o  (tx_valid_o),
    .rd_nibble_o (tx_nibble_o),
    .level_o     (fifo_level),
    .overflow_o  (fifo_ovf)
  );

  always_comb begin
    n = r;
    // Energy detect comes from the analog side
    n.ed_s1 = energy_detect_i;
    n.ed_s2 = r.ed_s1;

    // Write channel: address and data in either order
    aw_hs   = s_axi_awvalid_i && r.awready;
    w_hs    = s_axi_wvalid_i && r.wready;
    have_aw = r.aw_got || aw_hs;
    have_w  = r.w_got || w_hs;
    waddr   = r.aw_got ? r.awaddr : s_axi_awaddr_i;
    wval    = r.w_got ? r.wdata : s_axi_wdata_i[15:0];
    if (aw_hs) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr_i;
    end
    if (w_hs) begin
      n.w_got  = 1'b1;
      n.wdata  = s_axi_wdata_i[15:0];
      n.wlane1 = s_axi_wstrb_i[1];
    end
    if (r.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    commit  = have_aw && have_w && !r.bvalid;
    ctrl_wr = 1'b0;
    if (commit) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = PMC_RESP_OKAY;
      if (waddr == PMC_CTRL_ADDR) begin
        ctrl_wr = r.w_got ? r.wlane1 : s_axi_wstrb_i[1];
      end else if (waddr != PMC_STAT_ADDR) begin
        n.bresp = PMC_RESP_DECERR;
      end
    end
    if (ctrl_wr) begin
      n.ctrl = (r.ctrl & ~PMC_CTRL_WR_MASK) | (wval & PMC_CTRL_WR_MASK);
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    // Read channel
    stat_rd = 1'b0;
    if (r.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = PMC_RESP_OKAY;
      n.rdata  = 16'h0000;
      if (s_axi_araddr_i == PMC_CTRL_ADDR) begin
        n.rdata = r.ctrl & PMC_CTRL_WR_MASK;
      end else if (s_axi_araddr_i == PMC_STAT_ADDR) begin
        stat_rd = 1'b1;
        n.rdata[PMC_ST_STATE_LO+1:PMC_ST_STATE_LO] = r.st;
        n.rdata[PMC_ST_CLKOFF] = r.clk_off;
        n.rdata[PMC_ST_WOKEN]  = r.woken;
        n.rdata[PMC_ST_LEVEL_LO+3:PMC_ST_LEVEL_LO] = fifo_level;
        n.rdata[PMC_ST_OVF]    = r.ovf;
      end else begin
        n.rresp = PMC_RESP_DECERR;
      end
    end
    n.arready = !n.rvalid;

    // Overflow flag clears on status read, a new overflow wins
    if (stat_rd) begin
      n.ovf = 1'b0;
    end
    if (fifo_ovf) begin
      n.ovf = 1'b1;
    end

    sel = pmc_sel_t'(r.ctrl[PMC_PS_SEL_LO+1:PMC_PS_SEL_LO]);
    // Wake holds until software rewrites the control register
    if (!r.ctrl[PMC_PS_EN_BIT]) begin
      n.woken = 1'b0;
    end else if (r.ed_s2 &&
                 (r.st == PMC_ST_ASLEEP || r.st == PMC_ST_PSLEEP)) begin
      // wake on energy, wins over a write
      n.woken = 1'b1;
    end else if (ctrl_wr) begin
      n.woken = 1'b0;
    end
    if (!r.ctrl[PMC_PS_EN_BIT] || r.woken) begin
      n.st = PMC_ST_RUN;
    end else begin
      case (sel)
        PMC_SEL_NORMAL: n.st = PMC_ST_RUN;
        PMC_SEL_PDOWN:  n.st = PMC_ST_PDOWN;
        PMC_SEL_ASLEEP: n.st = PMC_ST_ASLEEP;
        PMC_SEL_PSLEEP: n.st = PMC_ST_PSLEEP;
        default:        n.st = PMC_ST_RUN;
      endcase
    end

    n.nlp = 1'b0;
    if (r.st != PMC_ST_ASLEEP) begin
      n.nlp_cnt = NLP_RELOAD;
    end else if (r.nlp_cnt == '0) begin
      // No pulse on the way out of active sleep
      n.nlp     = (n.st == PMC_ST_ASLEEP);
      n.nlp_cnt = NLP_RELOAD;
    end else begin
      n.nlp_cnt = r.nlp_cnt - 1'b1;
    end

    n.clk_off = r.ctrl[PMC_CLK_DIS_BIT] && (n.st == PMC_ST_PDOWN);
    n.pdown   = (n.st == PMC_ST_PDOWN);
    n.asleep  = (n.st == PMC_ST_ASLEEP);
    n.psleep  = (n.st == PMC_ST_PSLEEP);
    n.scr_byp = r.ctrl[PMC_SCR_BYP_BIT];
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r         <= '0;
      r.ctrl    <= PMC_CTRL_RST;
      r.st      <= PMC_ST_RUN;
      r.nlp_cnt <= NLP_RELOAD;
      r.awready <= 1'b1;
      r.wready  <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from registers
  assign s_axi_awready_o    = r.awready;
  assign s_axi_wready_o     = r.wready;
  assign s_axi_bresp_o      = r.bresp;
  assign s_axi_bvalid_o     = r.bvalid;
  assign s_axi_arready_o    = r.arready;
  assign s_axi_rdata_o      = {16'h0000, r.rdata};
  assign s_axi_rresp_o      = r.rresp;
  assign s_axi_rvalid_o     = r.rvalid;
  assign clocks_off_o       = r.clk_off;
  assign power_down_o       = r.pdown;
  assign active_sleep_o     = r.asleep;
  assign passive_sleep_o    = r.psleep;
  assign nlp_pulse_o        = r.nlp;
  assign scrambler_bypass_o = r.scr_byp;
endmodule : pmc_power_ctrl

// [testbench/pmc_chk_props.sv]
// Port checker for the power mode control block
`timescale 1ns/1ps
module pmc_chk
  import pmc_pkg::*;
#(
  parameter int unsigned NLP_PERIOD_CYC = PMC_NLP_CYC
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        clocks_off_o,
  input wire logic        power_down_o,
  input wire logic        active_sleep_o,
  input wire logic        passive_sleep_o,
  input wire logic        nlp_pulse_o,
  input wire logic        scrambler_bypass_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  property p_clk_off;
    clocks_off_o |-> power_down_o;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("clocks off outside power-down");
  property p_one_mode;
    $onehot0({power_down_o, active_sleep_o, passive_sleep_o});
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("more than one power mode");
  property p_nlp_mode;
    nlp_pulse_o |-> active_sleep_o;
  endproperty
  a_nlp_mode: assert property (p_nlp_mode)
    else $error("wake pulse outside active sleep");
  property p_nlp_gap;
    nlp_pulse_o |=> !nlp_pulse_o [*8];
  endproperty
  a_nlp_gap: assert property (p_nlp_gap)
    else $error("wake pulses too close");
  property p_bhold;
    s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  property p_rd_hi;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000 && !s_axi_arready_o;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("read upper half not zero");
  property p_wresp;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> s_axi_bvalid_o;
  endproperty
  a_wresp: assert property (p_wresp)
    else $error("no write response");
  property p_byp;
    $changed(scrambler_bypass_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o);
  endproperty
  a_byp: assert property (p_byp)
    else $error("bypass changed without write");
endmodule : pmc_chk

bind pmc_power_ctrl pmc_chk #(.NLP_PERIOD_CYC(NLP_PERIOD_CYC)) pmc_chk_inst (
  .clk_sys_i, .reset_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .clocks_off_o, .power_down_o, .active_sleep_o,
  .passive_sleep_o, .nlp_pulse_o, .scrambler_bypass_o);

// [testbench/pmc_link_partner.sv]
// Link partner model: received nibbles and line energy
`timescale 1ns/1ps
module pmc_link_partner (
  input  wire logic clk_sys_i,
  output logic      rx_valid_o,
  output logic [3:0] rx_nibble_o,
  output logic      energy_o
);
  logic [3:0] sent_q[$];
  logic [3:0] nib;
  int         to_send = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_nibble_o = 4'h0;
    energy_o = 1'b0;
  end
  // Idle data keeps toggling so a stale nibble is never mistaken
  always @(posedge clk_sys_i) begin
    if (to_send > 0) begin
      nib = 4'($urandom);
      rx_valid_o <= 1'b1;
      rx_nibble_o <= nib;
      sent_q.push_back(nib);
      to_send--;
    end else begin
      rx_valid_o <= 1'b0;
      rx_nibble_o <= ~rx_nibble_o;
    end
  end
  task send(input int n);
    @(negedge clk_sys_i);
    to_send = n;
  endtask : send
  task set_energy(input logic e);
    @(posedge clk_sys_i);
    energy_o <= e;
  endtask : set_energy
endmodule : pmc_link_partner

// [testbench/tb_top.sv]
// Self-checking bench of the power mode control block
`timescale 1ns/1ps
module tb_top
  import pmc_pkg::*;
();
  localparam int NLP = 20;
  logic clk_sys_i, reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, loopback_en_i;
  logic energy_detect_i, rx_valid_i, tx_valid_o, s_axi_awready_o;
  logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic clocks_off_o, power_down_o, active_sleep_o, passive_sleep_o;
  logic nlp_pulse_o, scrambler_bypass_o, seen, slow;
  logic [3:0]  rx_nibble_i, s_axi_wstrb_i, tx_nibble_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [15:0] exp_ctl;
  logic [3:0]  tx_q[$];
  int n_fail = 0, n_checks = 0, cyc = 0, first_at, c;
  int dep[4] = '{4, 5, 6, 8};
  pmc_link_partner pmc_link_partner_inst (.clk_sys_i,
    .rx_valid_o(rx_valid_i), .rx_nibble_o(rx_nibble_i),
    .energy_o(energy_detect_i));
  pmc_power_ctrl #(.NLP_PERIOD_CYC(NLP)) pmc_power_ctrl_inst (
    .clk_sys_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .energy_detect_i,
    .loopback_en_i, .rx_valid_i, .rx_nibble_i, .tx_valid_o, .tx_nibble_o,
    .clocks_off_o, .power_down_o, .active_sleep_o, .passive_sleep_o,
    .nlp_pulse_o, .scrambler_bypass_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end
  always @(posedge clk_sys_i) if (tx_valid_o === 1'b1) begin
    tx_q.push_back(tx_nibble_o);
    if (!seen) first_at = cyc;
    seen = 1'b1;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Responses may be taken late to exercise the hold rule
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [1:0] r);
    logic hs;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= !slow;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
      hs = s_axi_bvalid_o === 1'b1 && s_axi_bready_i === 1'b1;
    end while (!hs);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hs;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= !slow;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
      hs = s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1;
    end while (!hs);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : axr
  task wctl(input logic [15:0] v);
    logic [1:0] r;
    axw(PMC_CTRL_ADDR, {16'h0, v}, 4'hF, r);
    exp_ctl = v & 16'hFB00;
  endtask : wctl
  task rdchk;
    logic [31:0] d;
    logic [1:0]  r;
    axr(PMC_CTRL_ADDR, d, r);
    chk("ctrl", {16'h0, exp_ctl}, d);
    chk("rresp", 32'(PMC_RESP_OKAY), 32'(r));
  endtask : rdchk
  // Expected {clocks off, power-down, active, passive}
  function automatic logic [3:0] f_pw(input logic [15:0] v);
    if (!v[14]) return 4'h0;
    case (v[13:12])
      2'b01: return {v[15], 3'b100};
      2'b10: return 4'h2;
      2'b11: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction : f_pw
  task pwchk(input logic [15:0] v);
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("power", 32'(f_pw(v)), 32'({clocks_off_o, power_down_o,
        active_sleep_o, passive_sleep_o}));
  endtask : pwchk
  initial begin : main
    logic [31:0] d;
    logic [3:0]  s;
    logic [1:0]  r;
    int          base;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, slow} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, loopback_en_i, reset_n_i} = 4'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i} = 20'h0;
    s_axi_wdata_i = 32'h0;
    seen = 1'b0;
    void'($urandom(32'h81CD));
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    exp_ctl = 16'h0100;
    rdchk();
    wctl(16'hFFFF);
    rdchk();
    repeat (20) begin
      d = $urandom;
      s = 4'($urandom);
      slow = 1'($urandom);
      axw(PMC_CTRL_ADDR, d, s, r);
      if (s[1]) exp_ctl = d[15:0] & 16'hFB00;
      chk("bresp", 32'(PMC_RESP_OKAY), 32'(r));
      rdchk();
      chk("bypass", 32'(exp_ctl[11]), 32'(scrambler_bypass_o));
    end
    axw(8'h40, 32'hFFFF, 4'hF, r);
    chk("dec_w", 32'(PMC_RESP_DECERR), 32'(r));
    axr(8'h48, d, r);
    chk("dec_r", 32'(PMC_RESP_DECERR), 32'(r));
    rdchk();
    for (int i = 0; i < 4; i++) begin
      wctl({2'b11, i[1:0], 12'h100});
      pwchk({2'b11, i[1:0], 12'h100});
      if (i == 1) begin
        axr(PMC_STAT_ADDR, d, r);
        chk("status", 32'h0000_0005, d);
      end
      c = 0;
      if (i == 2) begin
        while (nlp_pulse_o !== 1'b1) @(posedge clk_sys_i);
        do begin
          @(posedge clk_sys_i);
          c++;
        end while (nlp_pulse_o !== 1'b1);
        chk("nlp", NLP, c);
      end
      if (i == 3) begin
        repeat (60) @(posedge clk_sys_i) if (nlp_pulse_o !== 1'b0) c++;
        chk("no_nlp", 0, c);
      end
      if (i >= 2) begin
        pmc_link_partner_inst.set_energy(1'b1);
        repeat (8) @(posedge clk_sys_i);
        chk("wake", 0, 32'({active_sleep_o, passive_sleep_o}));
        pmc_link_partner_inst.set_energy(1'b0);
      end
    end
    wctl(16'hB100);
    pwchk(16'hB100);
    loopback_en_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wctl({6'h0, k[1:0], 8'h00});
      seen = 1'b0;
      tx_q.delete();
      pmc_link_partner_inst.sent_q.delete();
      pmc_link_partner_inst.send(8);
      base = cyc;
      repeat (30) @(posedge clk_sys_i);
      c = first_at - base;
      // Write edge, drain start and output register
      chk("fill", dep[k] + 3, c);
      chk("count", 8, tx_q.size());
      foreach (tx_q[j])
        chk("nibble", pmc_link_partner_inst.sent_q[j], tx_q[j]);
    end
    loopback_en_i <= 1'b0;
    complete_run();
  end
endmodule : tb_top
